/* File: rtl/skp_pkg.sv */
package skp_pkg;
    // I/O port addresses of the four registers.
    localparam logic [7:0] SLOT_ADDR = 8'hA8;
    localparam logic [7:0] RETURN_ADDR = 8'hA9;
    localparam logic [7:0] DRIVE_ADDR = 8'hAA;
    localparam logic [7:0] MODE_ADDR = 8'hAB;
    // Reset values of the stored registers.
    localparam logic [7:0] SLOT_RESET = 8'h00;
    localparam logic [7:0] DRIVE_RESET = 8'h00;
    // Mode byte that clears both stored registers.
    localparam logic [7:0] MODE_CLEAR = 8'h82;
    // Field positions of the output register.
    localparam int ROW_LSB = 0;
    localparam int MOTOR_BIT = 4;
    localparam int WRITE_BIT = 5;
    localparam int LAMP_BIT = 6;
    localparam int SOUND_BIT = 7;
    // Field positions of a single-bit mode write.
    localparam int SB_VALUE_BIT = 0;
    localparam int SB_SEL_LSB = 1;
    localparam int SB_SEL_MSB = 3;
    localparam int SB_ZERO_LSB = 4;
    localparam int SB_ZERO_MSB = 7;
    // Value read back from an unmapped or write-only port.
    localparam logic [7:0] IDLE_READ = 8'hFF;
endpackage : skp_pkg

/* File: rtl/skp_slot_keyboard_ppi_port.sv */
// Behaviour
// - slot register picks slot per 16 KB page.
// - output bits 0-3 drive rows, readable.
// - output bit 4 drives tape motor.
// - output bit 5 drives tape write.
// - output bit 6 drives capital lamp.
// - output bit 7 drives click sound.
// - mode write 82h clears slot and output.
// - mode write, upper nibble zero, changes one bit.
// - bits 1-3 select bit, bit 0 value.
// - return port reads key return inputs, read-only.
// - ports at A8, A9, AA, AB; AB write-only.
`timescale 1ns/100ps
module skp_slot_keyboard_ppi_port (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioWrData,
    input wire logic ioWrEn,
    input wire logic ioRdEn,
    input wire logic [7:0] keyReturn,
    output logic [7:0] ioRdData,
    output logic [1:0] pageSlot0,
    output logic [1:0] pageSlot1,
    output logic [1:0] pageSlot2,
    output logic [1:0] pageSlot3,
    output logic [3:0] rowSelect,
    output logic tapeMotorCtrl,
    output logic tapeWriteOut,
    output logic capitalLamp,
    output logic clickSoundOut
);
    logic [7:0] slotPort_r;
    logic [7:0] slotPort_nxt;
    logic [7:0] drivePort_r;
    logic [7:0] drivePort_nxt;
    logic [7:0] ioRdData_r;
    logic [7:0] ioRdData_nxt;
    wire [7:0] bitMask;

    // Address decode of the four ports.
    wire slotHit = ioAddr == skp_pkg::SLOT_ADDR;
    wire returnHit = ioAddr == skp_pkg::RETURN_ADDR;
    wire driveHit = ioAddr == skp_pkg::DRIVE_ADDR;
    wire modeHit = ioAddr == skp_pkg::MODE_ADDR;
    wire slotWr = ioWrEn && slotHit;
    wire driveWr = ioWrEn && driveHit;
    wire modeWr = ioWrEn && modeHit;

    // Mode byte classification; other mode bytes are ignored.
    wire modeClear = modeWr && ioWrData == skp_pkg::MODE_CLEAR;
    wire modeSingle = modeWr
        && ioWrData[skp_pkg::SB_ZERO_MSB:skp_pkg::SB_ZERO_LSB]
        == 4'h0;
    wire [2:0] singleSel = ioWrData[skp_pkg::SB_SEL_MSB:skp_pkg::SB_SEL_LSB];
    wire singleVal = ioWrData[skp_pkg::SB_VALUE_BIT];

    // One-hot mask of the addressed output bit, one entry per bit.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign bitMask[gi] = singleSel == 3'(gi);
        end
    endgenerate

    // Next value of the slot register; single-bit writes leave it alone.
    assign slotPort_nxt = modeClear ? skp_pkg::SLOT_RESET
        : slotWr ? ioWrData : slotPort_r;

    // Next value of the output register; a single-bit write changes only the masked bit.
    assign drivePort_nxt = modeClear ? skp_pkg::DRIVE_RESET
        : driveWr ? ioWrData
        : modeSingle ? ((drivePort_r & ~bitMask)
            | ({8{singleVal}} & bitMask))
        : drivePort_r;

    // Read mux. Mode port is write-only and reads as idle bus level,
    // so software polling it sees no stale register contents.
    assign ioRdData_nxt = !ioRdEn ? ioRdData_r
        : slotHit ? slotPort_r
        : returnHit ? keyReturn
        : driveHit ? drivePort_r
        : skp_pkg::IDLE_READ;

    // Register storage.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slotPort_r <= skp_pkg::SLOT_RESET;
            drivePort_r <= skp_pkg::DRIVE_RESET;
            ioRdData_r <= skp_pkg::IDLE_READ;
        end else begin
            slotPort_r <= slotPort_nxt;
            drivePort_r <= drivePort_nxt;
            ioRdData_r <= ioRdData_nxt;
        end
    end

    // Outputs come straight from the stored registers.
    assign ioRdData = ioRdData_r;
    assign pageSlot0 = slotPort_r[1:0];
    assign pageSlot1 = slotPort_r[3:2];
    assign pageSlot2 = slotPort_r[5:4];
    assign pageSlot3 = slotPort_r[7:6];
    assign rowSelect =
        drivePort_r[skp_pkg::ROW_LSB+3:skp_pkg::ROW_LSB];
    assign tapeMotorCtrl = drivePort_r[skp_pkg::MOTOR_BIT];
    assign tapeWriteOut = drivePort_r[skp_pkg::WRITE_BIT];
    assign capitalLamp = drivePort_r[skp_pkg::LAMP_BIT];
    assign clickSoundOut = drivePort_r[skp_pkg::SOUND_BIT];

    // Output pins gathered back into bytes for the checks below.
    wire [7:0] slotPins = {pageSlot3, pageSlot2, pageSlot1, pageSlot0};
    wire [7:0] drivePins = {clickSoundOut, capitalLamp, tapeWriteOut,
        tapeMotorCtrl, rowSelect};

    // Checks next to the logic they guard.
    property p_slot_write;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hA8 |=> {pageSlot3, pageSlot2, pageSlot1,
            pageSlot0} == $past(ioWrData);
    endproperty
    a_slot_write: assert property (p_slot_write)
        else $error("Slot register did not take the write.");

    property p_drive_write;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAA |=> {clickSoundOut, capitalLamp,
            tapeWriteOut, tapeMotorCtrl, rowSelect} == $past(ioWrData);
    endproperty
    a_drive_write: assert property (p_drive_write)
        else $error("Output register pins do not follow the write.");

    property p_drive_read;
        @(posedge core_clk) disable iff (!reset_n)
        ioRdEn && ioAddr == 8'hAA |=> ioRdData == $past(drivePins);
    endproperty
    a_drive_read: assert property (p_drive_read)
        else $error("Output register read back wrong.");

    property p_motor_set;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData == 8'h09 |=> tapeMotorCtrl;
    endproperty
    a_motor_set: assert property (p_motor_set)
        else $error("Motor bit not set by single-bit write.");

    property p_write_reset;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData == 8'h0A |=> !tapeWriteOut;
    endproperty
    a_write_reset: assert property (p_write_reset)
        else $error("Tape write bit not reset by single-bit write.");

    property p_lamp_set;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData == 8'h0D |=> capitalLamp;
    endproperty
    a_lamp_set: assert property (p_lamp_set)
        else $error("Lamp bit not set by single-bit write.");

    property p_sound_set;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData == 8'h0F |=> clickSoundOut;
    endproperty
    a_sound_set: assert property (p_sound_set)
        else $error("Sound bit not set by single-bit write.");

    property p_clear;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData == 8'h82 |=>
            {pageSlot3, pageSlot2, pageSlot1, pageSlot0} == 8'h00
            && {clickSoundOut, capitalLamp, tapeWriteOut, tapeMotorCtrl,
            rowSelect} == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Clear mode byte did not clear both registers.");

    property p_single_keep;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData[7:4] == 4'h0 |=>
            $stable(slotPins) && ((drivePins ^ $past(drivePins))
            & ~(8'h01 << $past(ioWrData[3:1]))) == 8'h00;
    endproperty
    a_single_keep: assert property (p_single_keep)
        else $error("Single-bit write disturbed other bits.");

    property p_row_bit;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData[7:4] == 4'h0
            && ioWrData[3:1] < 3'h4 |=>
            rowSelect[$past(ioWrData[2:1])] == $past(ioWrData[0]);
    endproperty
    a_row_bit: assert property (p_row_bit)
        else $error("Addressed row bit has wrong value.");

    property p_return_read;
        @(posedge core_clk) disable iff (!reset_n)
        ioRdEn && ioAddr == 8'hA9 |=> ioRdData == $past(keyReturn);
    endproperty
    a_return_read: assert property (p_return_read)
        else $error("Key return read mismatch.");

    property p_mode_noread;
        @(posedge core_clk) disable iff (!reset_n)
        ioRdEn && ioAddr == 8'hAB |=> ioRdData == 8'hFF;
    endproperty
    a_mode_noread: assert property (p_mode_noread)
        else $error("Mode port returned data on read.");

    // Every bit position, not only the row bits, takes the written value.
    property p_single_any;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData[7:4] == 4'h0 |=>
            drivePins[$past(ioWrData[3:1])] == $past(ioWrData[0]);
    endproperty
    a_single_any: assert property (p_single_any)
        else $error("Addressed output bit has wrong value.");

    // The key return port has no storage, so a write must change nothing.
    property p_return_nowrite;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hA9 |=> $stable(slotPins)
            && $stable(drivePins);
    endproperty
    a_return_nowrite: assert property (p_return_nowrite)
        else $error("Write to key return port changed a register.");

    // Mode bytes that are neither a clear nor a single-bit write do nothing.
    property p_mode_ignored;
        @(posedge core_clk) disable iff (!reset_n)
        ioWrEn && ioAddr == 8'hAB && ioWrData != 8'h82
            && ioWrData[7:4] != 4'h0 |=> $stable(slotPins)
            && $stable(drivePins);
    endproperty
    a_mode_ignored: assert property (p_mode_ignored)
        else $error("Unrecognised mode byte changed a register.");

    // Read data stands between reads so a slow host can still pick it up.
    property p_read_hold;
        @(posedge core_clk) disable iff (!reset_n)
        !ioRdEn |=> $stable(ioRdData);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("Read data changed without a read strobe.");
endmodule : skp_slot_keyboard_ppi_port

/* File: verification/skp_host_model.sv */
`timescale 1ns/100ps
module skp_host_model (
    input wire logic core_clk,
    input wire logic [7:0] ioRdData,
    output logic [7:0] ioAddr,
    output logic [7:0] ioWrData,
    output logic ioWrEn,
    output logic ioRdEn
);
    // The bus idles with both strobes low.
    initial begin
        ioAddr = 8'h00;
        ioWrData = 8'h00;
        ioWrEn = 1'b0;
        ioRdEn = 1'b0;
    end
    // One write strobe; data is scrambled afterwards so nothing leans on it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        ioAddr = a;
        ioWrData = d;
        ioWrEn = 1'b1;
        @(negedge core_clk);
        ioWrEn = 1'b0;
        ioWrData = ~d;
    endtask : wr
    // One read strobe; the answer is settled by the following falling edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        ioAddr = a;
        ioRdEn = 1'b1;
        @(negedge core_clk);
        ioRdEn = 1'b0;
        d = ioRdData;
    endtask : rd
endmodule : skp_host_model

/* File: verification/test_slot_keyboard_ppi_port.sv */
`timescale 1ns/100ps
module test_slot_keyboard_ppi_port;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] ioAddr, ioWrData, keyReturn, ioRdData, rd, expDrv;
    logic ioWrEn, ioRdEn;
    logic [1:0] pageSlot0, pageSlot1, pageSlot2, pageSlot3;
    logic [3:0] rowSelect;
    logic tapeMotorCtrl, tapeWriteOut, capitalLamp, clickSoundOut;
    wire [7:0] slotPins = {pageSlot3, pageSlot2, pageSlot1, pageSlot0};
    wire [7:0] drvPins = {clickSoundOut, capitalLamp, tapeWriteOut,
        tapeMotorCtrl, rowSelect};
    int error_cnt = 0;
    int n_checks = 0;
    // Free-running 100 MHz clock.
    always #5 core_clk = ~core_clk;
    skp_host_model host_u (.core_clk(core_clk), .ioRdData(ioRdData),
        .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrEn(ioWrEn),
        .ioRdEn(ioRdEn));
    skp_slot_keyboard_ppi_port dut_u (.core_clk(core_clk),
        .reset_n(reset_n), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .keyReturn(keyReturn),
        .ioRdData(ioRdData), .pageSlot0(pageSlot0), .pageSlot1(pageSlot1),
        .pageSlot2(pageSlot2), .pageSlot3(pageSlot3),
        .rowSelect(rowSelect), .tapeMotorCtrl(tapeMotorCtrl),
        .tapeWriteOut(tapeWriteOut), .capitalLamp(capitalLamp),
        .clickSoundOut(clickSoundOut));
    // Compares a byte and counts the outcome.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // The whole run is about 65 cycles, so this only trips on a hang.
    initial begin
        #20000;
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    // Tests run in order; each leaves known register contents behind.
    initial begin
        keyReturn = 8'h3C;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        chk(slotPins, skp_pkg::SLOT_RESET);
        chk(drvPins, skp_pkg::DRIVE_RESET);
        host_u.rd(skp_pkg::MODE_ADDR, rd);
        chk(rd, skp_pkg::IDLE_READ);
        $display("Test reset done");
        host_u.wr(skp_pkg::SLOT_ADDR, 8'hE4);
        chk(slotPins, 8'hE4);
        host_u.rd(skp_pkg::SLOT_ADDR, rd);
        chk(rd, 8'hE4);
        host_u.wr(skp_pkg::DRIVE_ADDR, 8'hA5);
        chk(drvPins, 8'hA5);
        host_u.rd(skp_pkg::DRIVE_ADDR, rd);
        chk(rd, 8'hA5);
        $display("Test register access done");
        expDrv = 8'hA5;
        // Every bit is set then reset, so a wrong select shows on a neighbour.
        for (int i = 0; i < 8; i++) begin
            for (int v = 1; v >= 0; v--) begin
                host_u.wr(skp_pkg::MODE_ADDR, {4'h0, 3'(i), 1'(v)});
                expDrv[i] = 1'(v);
                chk(drvPins, expDrv);
            end
        end
        chk(slotPins, 8'hE4);
        host_u.wr(skp_pkg::MODE_ADDR, 8'h13);
        chk(drvPins, 8'h00);
        $display("Test single-bit writes done");
        host_u.rd(skp_pkg::RETURN_ADDR, rd);
        chk(rd, 8'h3C);
        host_u.wr(skp_pkg::RETURN_ADDR, 8'h00);
        chk(slotPins, 8'hE4);
        chk(drvPins, 8'h00);
        keyReturn = 8'hC3;
        host_u.rd(skp_pkg::RETURN_ADDR, rd);
        chk(rd, 8'hC3);
        $display("Test key return done");
        host_u.wr(skp_pkg::DRIVE_ADDR, 8'hFF);
        host_u.wr(skp_pkg::MODE_ADDR, skp_pkg::MODE_CLEAR);
        chk(slotPins, 8'h00);
        chk(drvPins, 8'h00);
        $display("Test clear done");
        // A reset in mid-run must drop both registers and the read data.
        host_u.wr(skp_pkg::SLOT_ADDR, 8'h5A);
        host_u.wr(skp_pkg::DRIVE_ADDR, 8'h3C);
        host_u.rd(skp_pkg::DRIVE_ADDR, rd);
        chk(rd, 8'h3C);
        reset_n = 1'b0;
        @(negedge core_clk);
        chk(slotPins, skp_pkg::SLOT_RESET);
        chk(drvPins, skp_pkg::DRIVE_RESET);
        chk(ioRdData, skp_pkg::IDLE_READ);
        reset_n = 1'b1;
        host_u.rd(skp_pkg::SLOT_ADDR, rd);
        chk(rd, skp_pkg::SLOT_RESET);
        $display("Test mid-run reset done");
        tally_and_finish();
    end
endmodule : test_slot_keyboard_ppi_port
